/* shared/fct_defs.svh */
// constants for the automatic flow control trigger
// Notes on behaviour
// R1: software keeps low threshold below high threshold
// R2: automatic jam lasts the coded duration, bits 7:4
// R3: duration code unused in full duplex
// R4: multicast selector jams multicast frames at level
// R5: broadcast selector jams broadcast frames at level
// R6: own address selector jams frames to us
// R7: frame type selectors unused in full duplex
// R8: any frame selector acts on every frame
// R9: full duplex pause needs any frame selector
// R10: half duplex any: jam on preamble, no decode
// R11: full duplex any: pause request at level
// R12: any frame selector overrides selectors 3 to 1
// R13: duration table, 10 Mbps adds 2.2 us
// R14: high threshold counts 64 byte units
// R15: one pause per high crossing, programmed time
// R16: zero pause below low, only after pause
// R17: transmitter disabled: no pause, no jam
// R18: level flag holds from high until below low
`ifndef FCT_DEFS_SVH
`define FCT_DEFS_SVH

// register byte addresses
`define FCT_ADDR_CFG 8'h00
`define FCT_ADDR_STAT 8'h04

// configuration field positions
`define FCT_HI_LSB 16
`define FCT_LO_LSB 8
`define FCT_DUR_LSB 4
`define FCT_SEL_MCAST 3
`define FCT_SEL_BCAST 2
`define FCT_SEL_OWN 1
`define FCT_SEL_ANY 0
`define FCT_CFG_RST 32'h00000000
`define FCT_CFG_MASK 32'h00FFFFFF

// status field positions
`define FCT_ST_LEVEL 0
`define FCT_ST_JAM 1
`define FCT_ST_PAUSED 2
`define FCT_ST_REQ 3
`define FCT_ST_OCC_LSB 16

// threshold unit of 64 bytes as a shift
`define FCT_THR_SHIFT 6

// timing
`define FCT_CLK_PERIOD_NS 4
`define FCT_T_5US_NS 5000
`define FCT_T_50US_NS 50000
`define FCT_T_10M_EXTRA_NS 2200
`define FCT_NS2CYC(ns) (((ns) + `FCT_CLK_PERIOD_NS - 1) / `FCT_CLK_PERIOD_NS)
`define FCT_JAM_5US_CYC `FCT_NS2CYC(`FCT_T_5US_NS)
`define FCT_JAM_50US_CYC `FCT_NS2CYC(`FCT_T_50US_NS)
`define FCT_JAM_10M_CYC `FCT_NS2CYC(`FCT_T_10M_EXTRA_NS)
`define FCT_CNT_W 18

`endif

/* shared/fct_pkg.sv */
// types shared by the flow control trigger modules
`include "fct_defs.svh"
package fct_pkg;
    typedef logic [15:0] fct_ptime_t;
    typedef enum logic [1:0] {
        FCT_P_IDLE,
        FCT_P_REQ_ON,
        FCT_P_PAUSED,
        FCT_P_REQ_OFF
    } fct_pause_st_t;
    typedef struct packed {
        logic [`FCT_CNT_W-1:0] cnt;
        logic active;
    } fct_tmr_state_t;
    typedef struct packed {
        logic level;
    } fct_lvl_state_t;
    typedef struct packed {
        logic [31:0] cfg;
        fct_pause_st_t pst;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic jam;
        logic pause_req;
        logic pause_zero;
        fct_ptime_t pause_time;
    } fct_top_state_t;
endpackage

/* shared/fct_if.sv */
// interfaces between the trigger core and its helpers
`timescale 1ns/1ns
interface fct_lvl_if #(parameter int OCC_W = 15);
    logic [7:0] high_threshold;
    logic [7:0] low_threshold;
    logic [OCC_W-1:0] occupancy;
    logic level_reached;
    modport ctl (output high_threshold, output low_threshold,
                 output occupancy, input level_reached);
    modport cmp (input high_threshold, input low_threshold,
                 input occupancy, output level_reached);
endinterface

interface fct_jam_if;
    logic start;
    logic abort;
    logic [3:0] jam_duration_code;
    logic speed_100;
    logic active;
    modport ctl (output start, output abort, output jam_duration_code,
                 output speed_100, input active);
    modport tmr (input start, input abort, input jam_duration_code,
                 input speed_100, output active);
endinterface

/* core/fct_level.sv */
// fifo level flag with high and low threshold hysteresis
`timescale 1ns/1ns
module fct_level #(
    parameter int OCC_W = 15
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // thresholds, occupancy, flag
    fct_lvl_if.cmp lvl
);
    import fct_pkg::*;

    fct_lvl_state_t st_reg;
    fct_lvl_state_t st_next;
    logic [15:0] occ_w;
    logic [15:0] hi_w;
    logic [15:0] lo_w;
    logic at_high;
    logic below_low;

    // thresholds scaled to bytes
    assign occ_w = 16'(lvl.occupancy);
    assign hi_w = 16'({lvl.high_threshold, 6'h00}); // R14
    assign lo_w = 16'({lvl.low_threshold, 6'h00});
    assign at_high = occ_w >= hi_w; // R14
    assign below_low = occ_w < lo_w;

    // set wins over clear, so a bad low setting never hides a high level
    always_comb begin
        st_next = st_reg;
        st_next.level = at_high || (st_reg.level && !below_low); // R18 R1
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lvl.level_reached = st_reg.level;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    chk_level_sets_high: assert property (at_high |=> lvl.level_reached) // R14
        else $error("level flag not set at high threshold");
    chk_level_band_hold: assert property ( // R18
        (lvl.level_reached && !below_low) |=> lvl.level_reached)
        else $error("level flag dropped inside the band");
    chk_level_idle_hold: assert property ( // R18
        (!lvl.level_reached && !at_high) |=> !lvl.level_reached)
        else $error("level flag rose below high threshold");
endmodule

/* core/fct_jam_timer.sv */
// back pressure duration timer
`timescale 1ns/1ns
`include "fct_defs.svh"
module fct_jam_timer #(
    parameter logic [`FCT_CNT_W-1:0] T5_CYC = `FCT_CNT_W'(`FCT_JAM_5US_CYC),
    parameter logic [`FCT_CNT_W-1:0] T50_CYC = `FCT_CNT_W'(`FCT_JAM_50US_CYC),
    parameter logic [`FCT_CNT_W-1:0] T10X_CYC = `FCT_CNT_W'(`FCT_JAM_10M_CYC)
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // start, abort, code and busy
    fct_jam_if.tmr jam
);
    import fct_pkg::*;

    fct_tmr_state_t st_reg;
    fct_tmr_state_t st_next;
    logic [`FCT_CNT_W-1:0] dur;
    logic [`FCT_CNT_W-1:0] run_cnt;
    logic [`FCT_CNT_W-1:0] dur_lat;

    // coded duration in cycles
    always_comb begin
        case (jam.jam_duration_code)
            4'h0: dur = T5_CYC; // R13
            4'h1: dur = T5_CYC + T5_CYC;
            4'h2: dur = (T5_CYC << 1) + T5_CYC;
            4'h3: dur = (T5_CYC << 2) + T5_CYC;
            default: dur = `FCT_CNT_W'(T50_CYC * (jam.jam_duration_code - 4'h3));
        endcase
        if (!jam.speed_100) begin
            dur = dur + T10X_CYC; // R13
        end
    end

    // count down; a start during a running jam is ignored
    always_comb begin
        st_next = st_reg;
        if (st_reg.active) begin
            if (jam.abort || st_reg.cnt == '0) begin
                st_next.active = 1'b0;
            end else begin
                st_next.cnt = st_reg.cnt - 1'b1; // R2
            end
        end else if (jam.start && !jam.abort) begin
            st_next.active = 1'b1;
            st_next.cnt = dur - 1'b1; // R2
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign jam.active = st_reg.active;

    // helper: length of each jam as seen
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_cnt <= '0;
            dur_lat <= '0;
        end else if (!st_reg.active && st_next.active) begin
            run_cnt <= `FCT_CNT_W'(1);
            dur_lat <= dur;
        end else if (st_reg.active && st_next.active) begin
            run_cnt <= run_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    chk_jam_hold_len: assert property ( // R2 R13
        ($fell(st_reg.active) && !$past(jam.abort)) |-> run_cnt == dur_lat)
        else $error("jam length differs from coded duration");
endmodule

/* core/fct_top.sv */
// automatic flow control trigger with apb register access
`timescale 1ns/1ns
`include "fct_defs.svh"
module fct_top #(
    parameter int OCC_W = 15,
    parameter int JAM_5US_CYC = `FCT_JAM_5US_CYC,
    parameter int JAM_50US_CYC = `FCT_JAM_50US_CYC,
    parameter int JAM_10M_EXTRA_CYC = `FCT_JAM_10M_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // mac mode and receive fifo state
    input wire logic full_duplex_i,
    input wire logic speed_100_i,
    input wire logic tx_enable_i,
    input wire logic [OCC_W-1:0] rx_fifo_used_i,
    // receive frame events
    input wire logic rx_preamble_i,
    input wire logic rx_da_valid_i,
    input wire logic rx_da_mcast_i,
    input wire logic rx_da_bcast_i,
    input wire logic rx_da_own_i,
    // pause frame request to the mac
    input wire fct_pkg::fct_ptime_t pause_time_value_i,
    input wire logic pause_ack_i,
    output logic pause_req_o,
    output logic pause_zero_o,
    output fct_pkg::fct_ptime_t pause_time_o,
    // half duplex back pressure
    output logic jam_o
);
    import fct_pkg::*;

    fct_top_state_t st_reg;
    fct_top_state_t st_next;

    fct_lvl_if #(.OCC_W(OCC_W)) lvl_bus();
    fct_jam_if jam_bus();

    logic [7:0] high_threshold;
    logic [7:0] low_threshold;
    logic [3:0] jam_duration_code;
    logic jam_on_multicast;
    logic jam_on_broadcast;
    logic jam_on_own_address;
    logic act_on_any_frame;
    logic level;
    logic hd_ok;
    logic fd_ok;
    logic sel_hit;
    logic apb_setup;
    logic apb_wr_cfg;
    logic addr_hit;
    logic req_acked;
    logic [31:0] stat_word;
    logic [31:0] rd_word;

    // configuration fields
    assign high_threshold = st_reg.cfg[`FCT_HI_LSB +: 8];
    assign low_threshold = st_reg.cfg[`FCT_LO_LSB +: 8];
    assign jam_duration_code = st_reg.cfg[`FCT_DUR_LSB +: 4];
    assign jam_on_multicast = st_reg.cfg[`FCT_SEL_MCAST];
    assign jam_on_broadcast = st_reg.cfg[`FCT_SEL_BCAST];
    assign jam_on_own_address = st_reg.cfg[`FCT_SEL_OWN];
    assign act_on_any_frame = st_reg.cfg[`FCT_SEL_ANY];

    // level flag with hysteresis
    assign lvl_bus.high_threshold = high_threshold;
    assign lvl_bus.low_threshold = low_threshold;
    assign lvl_bus.occupancy = rx_fifo_used_i;
    assign level = lvl_bus.level_reached;

    fct_level #(
        .OCC_W(OCC_W)
    ) u_level (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .lvl(lvl_bus.cmp)
    );

    // mode gates: no flow control at all while the transmitter is off
    assign hd_ok = tx_enable_i && !full_duplex_i; // R17 R3 R7
    assign fd_ok = tx_enable_i && full_duplex_i && act_on_any_frame; // R9 R17

    // frame selectors; any frame skips address decode and wins
    always_comb begin
        if (act_on_any_frame) begin
            sel_hit = rx_preamble_i; // R8 R10 R12
        end else begin
            sel_hit = rx_da_valid_i &&
                ((jam_on_multicast && rx_da_mcast_i) || // R4
                 (jam_on_broadcast && rx_da_bcast_i) || // R5
                 (jam_on_own_address && rx_da_own_i)); // R6
        end
    end

    // jam timer control
    assign jam_bus.start = hd_ok && level && sel_hit; // R4 R5 R6 R10
    assign jam_bus.abort = !hd_ok; // R3 R17
    assign jam_bus.jam_duration_code = jam_duration_code; // R2
    assign jam_bus.speed_100 = speed_100_i;

    fct_jam_timer #(
        .T5_CYC(`FCT_CNT_W'(JAM_5US_CYC)),
        .T50_CYC(`FCT_CNT_W'(JAM_50US_CYC)),
        .T10X_CYC(`FCT_CNT_W'(JAM_10M_EXTRA_CYC))
    ) u_jam_timer (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .jam(jam_bus.tmr)
    );

    // apb decode
    assign apb_setup = psel_i && !penable_i;
    assign addr_hit = (paddr_i == `FCT_ADDR_CFG) ||
                      (paddr_i == `FCT_ADDR_STAT);
    assign apb_wr_cfg = psel_i && penable_i && pwrite_i && st_reg.pready &&
                        (paddr_i == `FCT_ADDR_CFG);
    assign req_acked = st_reg.pause_req && pause_ack_i;

    // status word
    always_comb begin
        stat_word = 32'h00000000;
        stat_word[`FCT_ST_LEVEL] = level;
        stat_word[`FCT_ST_JAM] = st_reg.jam;
        stat_word[`FCT_ST_PAUSED] = (st_reg.pst == FCT_P_PAUSED);
        stat_word[`FCT_ST_REQ] = st_reg.pause_req;
        stat_word[`FCT_ST_OCC_LSB +: 16] = 16'(rx_fifo_used_i);
    end

    // read multiplexer
    always_comb begin
        case (paddr_i)
            `FCT_ADDR_CFG: rd_word = st_reg.cfg & `FCT_CFG_MASK;
            `FCT_ADDR_STAT: rd_word = stat_word;
            default: rd_word = 32'h00000000;
        endcase
    end

    // next state of the whole block
    always_comb begin
        st_next = st_reg;

        // zero wait apb answer, loaded in the setup cycle
        st_next.pready = apb_setup;
        st_next.pslverr = apb_setup && !addr_hit;
        st_next.prdata = (apb_setup && !pwrite_i) ? rd_word : 32'h00000000;
        if (apb_wr_cfg) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb_i[b]) begin
                    st_next.cfg[b*8 +: 8] = pwdata_i[b*8 +: 8];
                end
            end
            st_next.cfg = st_next.cfg & `FCT_CFG_MASK;
        end

        // back pressure output follows the timer, cut at once on mode loss
        st_next.jam = jam_bus.active && hd_ok; // R2 R3 R17

        // full duplex pause sequencing
        case (st_reg.pst)
            FCT_P_IDLE: begin
                if (fd_ok && level) begin
                    st_next.pst = FCT_P_REQ_ON; // R11
                end
            end
            FCT_P_REQ_ON: begin
                if (req_acked) begin
                    st_next.pst = FCT_P_PAUSED; // R15
                end else if (!fd_ok) begin
                    st_next.pst = FCT_P_IDLE; // R9 R17
                end
            end
            FCT_P_PAUSED: begin
                if (fd_ok && !level) begin
                    st_next.pst = FCT_P_REQ_OFF; // R16
                end
            end
            FCT_P_REQ_OFF: begin
                if (req_acked) begin
                    st_next.pst = FCT_P_IDLE;
                end
            end
            default: begin
                st_next.pst = FCT_P_IDLE;
            end
        endcase

        // request held until the mac takes it, and only while fd_ok is high
        st_next.pause_req = fd_ok && ((st_next.pst == FCT_P_REQ_ON) ||
                            (st_next.pst == FCT_P_REQ_OFF)); // R11 R17
        st_next.pause_zero = (st_next.pst == FCT_P_REQ_OFF); // R16
        if (st_next.pst == FCT_P_REQ_OFF) begin
            st_next.pause_time = 16'h0000; // R16
        end else begin
            st_next.pause_time = pause_time_value_i; // R15
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
            st_reg.cfg <= `FCT_CFG_RST;
            st_reg.pst <= FCT_P_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign prdata_o = st_reg.prdata;
    assign pready_o = st_reg.pready;
    assign pslverr_o = st_reg.pslverr;
    assign pause_req_o = st_reg.pause_req;
    assign pause_zero_o = st_reg.pause_zero;
    assign pause_time_o = st_reg.pause_time;
    assign jam_o = st_reg.jam;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    // apb timing
    sequence s_apb_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_apb_done;
        pready_o ##1 !pready_o;
    endsequence

    chk_apb_zero_wait: assert property (s_apb_setup |=> s_apb_done)
        else $error("apb answer not one access cycle");
    chk_apb_bad_addr: assert property (
        (s_apb_setup and !addr_hit) |=> (pready_o && pslverr_o))
        else $error("unmapped address not flagged");
    chk_cfg_write_lands: assert property (
        (apb_wr_cfg && pstrb_i == 4'hF) |=>
        st_reg.cfg == ($past(pwdata_i) & `FCT_CFG_MASK))
        else $error("configuration write lost");

    // half duplex gating
    chk_fd_no_jam: assert property (full_duplex_i |=> !jam_o) // R3 R7
        else $error("back pressure in full duplex");
    chk_txoff_quiet: assert property ( // R17
        !tx_enable_i |=> (!jam_o && !pause_req_o))
        else $error("flow control while transmitter off");
    chk_any_preamble_jam: assert property ( // R10 R8
        (hd_ok && level && act_on_any_frame && rx_preamble_i &&
         !jam_bus.active) ##1 hd_ok |=> jam_o)
        else $error("preamble did not start back pressure");
    chk_sel_mcast_jam: assert property ( // R4
        (hd_ok && level && !act_on_any_frame && jam_on_multicast &&
         rx_da_valid_i && rx_da_mcast_i && !jam_bus.active)
        ##1 hd_ok |=> jam_o)
        else $error("multicast frame not jammed");
    chk_any_ignores_sel: assert property ( // R12
        (act_on_any_frame && !rx_preamble_i) |-> !jam_bus.start)
        else $error("selector acted while any frame set");

    // full duplex pause sequencing
    sequence s_pause_taken;
        (st_reg.pst == FCT_P_REQ_ON) && req_acked;
    endsequence
    sequence s_level_gone;
        fd_ok && !level;
    endsequence

    // checked one edge after the request, before any ack can remove it
    chk_fd_needs_any: assert property ( // R9
        (st_reg.pst == FCT_P_IDLE && !act_on_any_frame) |=>
        (st_reg.pst == FCT_P_IDLE && !pause_req_o))
        else $error("pause without any frame selector");
    chk_fd_pause_req: assert property ( // R11
        (st_reg.pst == FCT_P_IDLE && fd_ok && level) |=>
        (pause_req_o && !pause_zero_o))
        else $error("pause not requested at level");
    chk_pause_single: assert property ( // R15
        (st_reg.pst == FCT_P_PAUSED && level) |=> !pause_req_o)
        else $error("second pause in one crossing");
    chk_zero_pause: assert property ( // R16
        s_pause_taken ##1 s_level_gone |=>
        (pause_req_o && pause_zero_o && pause_time_o == 16'h0000))
        else $error("zero pause not requested");
endmodule

/* verification/fct_link_partner.sv */
// link partner model: a frame is a preamble, then its address class
`timescale 1ns/1ns
module fct_link_partner (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // frame request from the bench
    input wire logic frame_go_i,
    input wire logic [2:0] frame_cls_i,
    // receive events toward the trigger
    output logic rx_preamble_o,
    output logic rx_da_valid_o,
    output logic [2:0] rx_cls_o
);
    logic [2:0] sr_reg;
    logic [2:0] cls_reg;
    logic tog_reg;
    // preamble one cycle after the request, address two cycles later
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sr_reg <= 3'h0;
            cls_reg <= 3'h0;
            tog_reg <= 1'b0;
        end else begin
            sr_reg <= {sr_reg[1:0], frame_go_i};
            tog_reg <= ~tog_reg;
            if (frame_go_i) begin
                cls_reg <= frame_cls_i;
            end
        end
    end
    assign rx_preamble_o = sr_reg[0];
    assign rx_da_valid_o = sr_reg[2];
    // class lines change every cycle outside the address cycle
    assign rx_cls_o = sr_reg[2] ? cls_reg : {3{tog_reg}};
endmodule

/* verification/testbench.sv */
// self-checking bench for the flow control trigger
`timescale 1ns/1ns
`include "fct_defs.svh"
module testbench;
    import fct_pkg::*;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, er, fd = 1'b0, spd = 1'b1, tx = 1'b1;
    logic [14:0] occ = 15'h0;
    logic pre, dav, go = 1'b0, ack = 1'b0, req, zero, jam;
    logic [2:0] cls, gcls = 3'h0;
    fct_ptime_t ptv = 16'h0, pto;
    logic [31:0] cfg, r;
    int error_cnt = 0, tests_run = 0, cyc = 0, lvl = 0, len, pc, n;
    // 4 ns system clock
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    fct_top #(.OCC_W(15), .JAM_5US_CYC(5), .JAM_50US_CYC(20),
        .JAM_10M_EXTRA_CYC(3)) i_dut (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .full_duplex_i(fd), .speed_100_i(spd),
        .tx_enable_i(tx), .rx_fifo_used_i(occ), .rx_preamble_i(pre),
        .rx_da_valid_i(dav), .rx_da_mcast_i(cls[2]),
        .rx_da_bcast_i(cls[1]), .rx_da_own_i(cls[0]),
        .pause_time_value_i(ptv), .pause_ack_i(ack), .pause_req_o(req),
        .pause_zero_o(zero), .pause_time_o(pto), .jam_o(jam));
    fct_link_partner i_partner (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .frame_go_i(go), .frame_cls_i(gcls),
        .rx_preamble_o(pre), .rx_da_valid_o(dav), .rx_cls_o(cls));
    task complete_run;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t: apb answer timed out", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task wcfg(input logic [31:0] v);
        cfg = v & `FCT_CFG_MASK;
        apb(1'b1, `FCT_ADDR_CFG, v, 4'hF);
    endtask
    // occupancy change with the hysteresis model and status read
    task set_occ(input int v);
        @(posedge clk_sys_i);
        occ <= 15'(v);
        repeat (3) @(posedge clk_sys_i);
        if (v >= cfg[23:16] * 64) lvl = 1;
        else if (v < cfg[15:8] * 64) lvl = 0;
        apb(1'b0, `FCT_ADDR_STAT, 32'h0, 4'hF);
        chk(rd[0], 32'(lvl));
        chk(rd[31:16], 32'(v));
    endtask
    function automatic int exp_jam(input logic [2:0] c);
        int d;
        if (fd || !tx || lvl == 0) return 0;
        if (!cfg[0] && (cfg[3:1] & c) == 3'h0) return 0;
        d = cfg[7:4] < 4 ? 5 * (cfg[7:4] == 3 ? 5 : cfg[7:4] + 1)
                         : (cfg[7:4] - 3) * 20;
        return spd ? d : d + 3;
    endfunction
    // one frame; counts jam and pause request cycles in a fixed window
    task frame(input logic [2:0] c);
        @(posedge clk_sys_i);
        go <= 1'b1;
        gcls <= c;
        @(posedge clk_sys_i);
        go <= 1'b0;
        len = 0;
        pc = 0;
        repeat (300) begin
            @(posedge clk_sys_i);
            len += (jam === 1'b1);
            pc += (req === 1'b1);
        end
        chk(len, exp_jam(c));
        chk(pc, 0);
    endtask
    // wait for a pause request, check it, then acknowledge it
    task pause(input logic z, input fct_ptime_t t);
        n = 0;
        while (req !== 1'b1 && n < 100) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk(n < 100, 1);
        chk({zero, pto}, {z, t});
        ack <= 1'b1;
        @(posedge clk_sys_i);
        ack <= 1'b0;
        pc = 0;
        repeat (100) begin
            @(posedge clk_sys_i);
            pc += (req === 1'b1);
        end
        chk(pc, 0);
    endtask
    // hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            $display("ERROR %0t: run timed out", $time);
            complete_run;
        end
    end
    initial begin
        r = $urandom(96);
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        apb(1'b0, `FCT_ADDR_CFG, 32'h0, 4'hF);
        chk(rd, `FCT_CFG_RST);
        apb(1'b0, 8'h08, 32'h0, 4'hF);
        chk(er, 1'b1);
        r = $urandom;
        wcfg(r);
        apb(1'b0, `FCT_ADDR_CFG, 32'h0, 4'hF);
        chk(rd, cfg);
        apb(1'b1, `FCT_ADDR_CFG, ~r, 4'h1);
        apb(1'b0, `FCT_ADDR_CFG, 32'h0, 4'hF);
        chk(rd, {8'h00, r[23:8], ~r[7:0]});
        wcfg(32'h00020101);
        set_occ(127);
        frame(3'h0);
        set_occ(128);
        set_occ(70);
        // every duration code at both speeds
        for (int s = 0; s < 2; s++) begin
            spd <= s[0];
            for (int c = 0; c < 16; c++) begin
                wcfg(32'h00020101 | (c << 4));
                frame(3'(c));
            end
        end
        // each type selector against each class
        for (int b = 1; b < 4; b++) begin
            wcfg(32'h00020120 | (1 << b));
            for (int c = 0; c < 4; c++) frame(3'((1 << c) >> 1));
        end
        wcfg(32'h0002012F);
        frame(3'h0);
        tx <= 1'b0;
        frame(3'h0);
        fd <= 1'b1;
        wcfg(32'h0002012E);
        tx <= 1'b1;
        frame(3'h7);
        ptv <= 16'($urandom);
        wcfg(32'h00020121);
        pause(1'b0, ptv);
        set_occ(30);
        pause(1'b1, 16'h0);
        complete_run;
    end
endmodule
